// file: hw/port_io_fault_monitor_defs.vh
// Constants of the port configuration and fault monitor block
`ifndef PORT_IO_FAULT_MONITOR_DEFS_VH
`define PORT_IO_FAULT_MONITOR_DEFS_VH

// Register indices carried by the decoded command port
`define REG_TBL 4'h0
`define REG_PAL 4'h1
`define REG_PBL 4'h2
`define REG_DIRECTION_A 4'h3
`define REG_DIRECTION_B 4'h4
`define REG_IAM 4'h5
`define REG_IBM 4'h6
`define REG_DESIRED_VALUE_A 4'h7
`define REG_DESIRED_VALUE_B 4'h8
`define REG_IAE 4'h9
`define REG_IBE 4'ha
`define REG_PCR 4'hb
`define REG_ICR 4'hd
`define REG_FCR 4'he

// Port configuration fields
`define PCR_TRI 7
`define PCR_CEM 6
`define PCR_MODE_HI 5
`define PCR_MODE_LO 3
`define PCR_PLS 2
`define PCR_EGA 1
`define PCR_READY_POLARITY 0

// Port mode codes (top bit clear is general I/O)
`define MODE_MULTI 3'h4
`define MODE_SINGLE 3'h5
`define MODE_OUT 3'h6
`define MODE_BIDIR 3'h7

// Interrupt configuration fields
`define ICR_INTR_OR_ROUTE 6
`define ICR_BAD_CMD_INTR_EN 5
`define ICR_RX_READY_INTR_EN 4
`define ICR_TX_EMPTY_INTR_EN 3
`define ICR_PIN_ERROR_INTR_EN 2
`define ICR_ENA 1
`define ICR_ENB 0
`define ICR_WMASK 8'h7f

// Threshold and lock fields
`define TBL_TU_HI 7
`define TBL_TU_LO 5
`define TBL_TL_HI 4
`define TBL_TL_LO 2
`define TBL_ADS 1
`define TBL_BL 0

// Port B pins used by the handshake
`define PB_EXT_STROBE_IN 7
`define PB_XMIT_EMPTY_OUT 6
`define PB_RX_FULL_OUT 5
`define PB_PEN 4

// Reset values and special codes
`define RST_BYTE 8'h00
`define RST_FC 1'b1
`define RST_XRE 1'b1
`define FCR_UNKNOWN 8'hff
`define NV_B_ALWAYS 8'h0f

`endif

// file: hw/port_io_fault_monitor.v
// Port configuration, handshake, fault monitor and interrupt logic of the dual port
//
// How it works
// - Mode field: 0xx general, 100..111 handshake modes
// - Pulse-select 0 interlocked, 1 pulsed strobes
// - Edge-select 0 falling, 1 rising strobe edge
// - Polarity bit sets ready/strobe active level
// - Output mode: tri-state bit floats port A
// - Port enable low mutes interrupts, optionally floats
// - Direction bit per pin: 0 input, 1 output
// - Handshake ignores direction A and B7..B4
// - Desired A nonvolatile only in general mode
// - Desired B low nibble always nonvolatile
// - Latch A on read, or on strobe edge
// - Latch B always on its read command
// - Mask bit 0 monitors the pin
// - Error flag when pin differs from desired
// - Pin errors interrupt only when enabled
// - Routing bit ORs both interrupt sources
// - Failed command interrupts only when enabled
// - Ready and empty flags, when enabled, raise interrupt A
// - Output enables gate interrupts; top bit zero
// - Failed record: FFh or the received opcode
// - Writes hit both parts; restore at power-up
// - Analog select picks comparator thresholds
// - Reading failed record clears interrupts, flag
`timescale 1ns/1ns
`default_nettype none
`include "port_io_fault_monitor_defs.vh"

module port_io_fault_monitor (
  input wire clk, // 100 MHz clock
  input wire rst, // Synchronous reset, active high
  input wire cmd_valid, // Decoded register command, one cycle
  input wire cmd_write, // 1 write, 0 read
  input wire [3:0] cmd_reg, // Register index
  input wire [7:0] cmd_wdata, // Write data
  output reg [7:0] rd_data_q, // Read data
  output reg rd_valid_q, // Read data valid pulse
  input wire bad_cmd, // Bad command detected, one cycle
  input wire bad_cmd_opcode_fault, // 1 unknown or incomplete opcode
  input wire [7:0] bad_cmd_opcode, // Opcode received with bad command
  input wire [7:0] nv_restore_a, // Nonvolatile copy of desired A
  input wire [7:0] nv_restore_b, // Nonvolatile copy of desired B
  output reg nv_write_a_q, // Start nonvolatile write of desired A
  output reg nv_write_b_q, // Start nonvolatile write of desired B
  output reg [7:0] nv_write_b_mask_q, // Bits of desired B to mirror
  output wire [7:0] desired_value_a, // Desired A, also nonvolatile data
  output wire [7:0] desired_value_b, // Desired B, also nonvolatile data
  input wire [7:0] pa_in, // Port A pin levels
  output reg [7:0] pa_out_q, // Port A drive value
  output reg [7:0] pa_oe_q, // Port A output enables
  input wire [7:0] pa_analog_in, // Port A comparator results
  input wire [7:0] pb_in, // Port B pin levels
  output reg [7:0] pb_out_q, // Port B drive value
  output reg [7:0] pb_oe_q, // Port B output enables
  input wire port_enable_in, // Port enable pin
  output reg intr_out_a, // Interrupt A request, active high
  output reg intr_out_b, // Interrupt B request, active high
  output wire [2:0] upper_threshold_code, // Threshold for pins A7..A4
  output wire [2:0] lower_threshold_code, // Threshold for pins A3..A0
  output wire analog_select, // Comparator mode selected
  output wire block_lock, // Memory block lock
  output wire rx_ready_flag, // Receive data ready
  output wire tx_empty_flag, // Transmit register empty
  output wire bad_cmd_flag // Failed command seen
);

  // Bidirectional slave transaction states
  localparam [2:0] BI_IDLE = 3'b001;
  localparam [2:0] BI_READ = 3'b010;
  localparam [2:0] BI_WRITE = 3'b100;

  // Port B pins taken by the handshake in each mode
  function [7:0] hs_pins;
    input [2:0] mode;
    begin
      case (mode)
        `MODE_MULTI: hs_pins = 8'h40;
        `MODE_SINGLE: hs_pins = 8'hc0;
        `MODE_OUT: hs_pins = 8'ha0;
        `MODE_BIDIR: hs_pins = 8'hf0;
        default: hs_pins = 8'h00;
      endcase
    end
  endfunction

  // Register file
  reg [7:0] tbl_q, dva_q, dvb_q, pcr_q, dda_q, ddb_q, iam_q, ibm_q, icr_q, fcr_q;
  reg [7:0] pal_q, pbl_q, iae_q, ibe_q;
  reg fc_q, rdr_q, xre_q, irq_a_q, irq_b_q, restore_q;
  reg [2:0] bi_q;
  reg [2:0] bi_d;

  // Two-flop synchronisers for pin inputs
  reg [7:0] pa_m, pa_s, an_m, an_s, pb_m, pb_s;
  reg pce_m, pce_s, ext_strobe_in_prev_q;

  always @(posedge clk) begin
    pa_m <= pa_in;
    pa_s <= pa_m;
    an_m <= pa_analog_in;
    an_s <= an_m;
    pb_m <= pb_in;
    pb_s <= pb_m;
    pce_m <= port_enable_in;
    pce_s <= pce_m;
    ext_strobe_in_prev_q <= pb_s[`PB_EXT_STROBE_IN];
  end

  // Configuration fields
  wire [2:0] mode = pcr_q[`PCR_MODE_HI:`PCR_MODE_LO];
  wire hs = mode[2];
  wire m_multi = (mode == `MODE_MULTI);
  wire m_single = (mode == `MODE_SINGLE);
  wire m_out = (mode == `MODE_OUT);
  wire m_bidir = (mode == `MODE_BIDIR);
  wire pulse_select = pcr_q[`PCR_PLS];
  wire ready_polarity = pcr_q[`PCR_READY_POLARITY];
  wire [7:0] hs_mask = hs_pins(mode);

  // Command decode
  wire rd_cmd = cmd_valid & ~cmd_write;
  wire wr_cmd = cmd_valid & cmd_write;
  wire rd_pal = rd_cmd & (cmd_reg == `REG_PAL);
  wire rd_pbl = rd_cmd & (cmd_reg == `REG_PBL);
  wire rd_fcr = rd_cmd & (cmd_reg == `REG_FCR);
  wire wr_dva = wr_cmd & (cmd_reg == `REG_DESIRED_VALUE_A);
  wire wr_dvb = wr_cmd & (cmd_reg == `REG_DESIRED_VALUE_B);

  // Sensed port A level: digital half-supply or comparator thresholds
  wire [7:0] sense_a = tbl_q[`TBL_ADS] ? an_s : pa_s;

  // Strobe edge detection on the synchronised pin
  wire ext_strobe_in_cur = pb_s[`PB_EXT_STROBE_IN];
  wire ext_strobe_in_act = pcr_q[`PCR_EGA] ? (~ext_strobe_in_prev_q & ext_strobe_in_cur)
                                  : (ext_strobe_in_prev_q & ~ext_strobe_in_cur);

  // Bidirectional slave controls
  wire pen_s = pb_s[`PB_PEN];
  wire rw_s = pb_s[`PB_EXT_STROBE_IN];
  wire bi_rd_end = (bi_q == BI_READ) & pen_s;
  wire bi_wr_end = (bi_q == BI_WRITE) & (pen_s | rw_s);

  // Slave transaction sequencing, only alive in bidirectional mode
  always @* begin
    bi_d = bi_q;
    case (bi_q)
      BI_IDLE: begin
        if (m_bidir & ~pen_s) begin
          bi_d = rw_s ? BI_READ : BI_WRITE;
        end
      end
      BI_READ: begin
        if (pen_s | ~m_bidir) begin
          bi_d = BI_IDLE;
        end
      end
      BI_WRITE: begin
        if (pen_s | rw_s | ~m_bidir) begin
          bi_d = BI_IDLE;
        end
      end
      default: bi_d = BI_IDLE;
    endcase
  end

  // Handshake flag events; setting outweighs clearing in the same cycle
  wire cap_single = m_single & ext_strobe_in_act & ~rdr_q;
  wire rdr_set = cap_single | (m_bidir & bi_wr_end);
  wire rdr_clr = rd_pal & (m_single | m_bidir);
  wire xre_set = (m_out & ext_strobe_in_act) | (m_bidir & bi_rd_end);
  wire xre_clr = wr_dva & (m_out | m_bidir);

  // Port A latch source: pins at read decode, or strobed/slave-written data
  wire pal_on_read = rd_pal & (~hs | m_multi);
  wire pal_on_hs = cap_single | (m_bidir & bi_wr_end);

  // Ready/strobe levels before polarity, interlocked or one-cycle pulses
  reg act6, act5;
  always @* begin
    act6 = 1'b0;
    act5 = 1'b0;
    case (mode)
      `MODE_MULTI: act6 = rd_pal;
      `MODE_SINGLE: act6 = pulse_select ? rd_pal : ~rdr_q;
      `MODE_OUT: act5 = pulse_select ? wr_dva : ~xre_q;
      `MODE_BIDIR: begin
        act6 = pulse_select ? bi_rd_end : xre_q;
        act5 = pulse_select ? wr_dva : ~xre_q;
      end
      default: begin
        act6 = 1'b0;
        act5 = 1'b0;
      end
    endcase
  end

  // Pin drive and enables, registered so the pins never see decode glitches
  reg [7:0] pa_oe_d, pb_oe_d, pb_out_d;
  always @* begin
    pa_oe_d = dda_q;
    if (m_out) begin
      pa_oe_d = {8{~pcr_q[`PCR_TRI]}};
    end else if (m_bidir) begin
      pa_oe_d = {8{~pen_s & rw_s}};
    end else if (hs) begin
      pa_oe_d = `RST_BYTE;
    end
    pb_oe_d = ddb_q;
    pb_out_d = dvb_q;
    if (hs) begin
      pb_oe_d[7:4] = 4'h0;
      pb_out_d[7:4] = 4'h0;
      pb_oe_d[`PB_XMIT_EMPTY_OUT] = m_multi | m_single | m_bidir;
      pb_oe_d[`PB_RX_FULL_OUT] = m_out | m_bidir;
      pb_out_d[`PB_XMIT_EMPTY_OUT] = ready_polarity ? act6 : ~act6;
      pb_out_d[`PB_RX_FULL_OUT] = ready_polarity ? act5 : ~act5;
    end
    if (pcr_q[`PCR_CEM] & ~pce_s) begin
      pa_oe_d = `RST_BYTE;
      pb_oe_d = `RST_BYTE;
    end
  end

  // Interrupt sources per port
  wire pin_err_en = icr_q[`ICR_PIN_ERROR_INTR_EN];
  // The clearing read retires the failed-command source, or its own request would survive the read
  wire fc_src = icr_q[`ICR_BAD_CMD_INTR_EN] & fc_q & ~rd_fcr;
  wire src_a = (pin_err_en & (|iae_q)) | fc_src
             | (icr_q[`ICR_RX_READY_INTR_EN] & rdr_q) | (icr_q[`ICR_TX_EMPTY_INTR_EN] & xre_q);
  wire src_b = (pin_err_en & (|ibe_q)) | fc_src;
  wire route = icr_q[`ICR_INTR_OR_ROUTE];
  wire req_a = route ? (irq_a_q | irq_b_q) : irq_a_q;
  wire req_b = route ? (irq_a_q | irq_b_q) : irq_b_q;

  // Read data mux
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = `RST_BYTE;
    case (cmd_reg)
      `REG_TBL: rd_mux = tbl_q;
      `REG_PAL: rd_mux = pal_on_read ? sense_a : pal_q;
      `REG_PBL: rd_mux = pb_s;
      `REG_DIRECTION_A: rd_mux = dda_q;
      `REG_DIRECTION_B: rd_mux = ddb_q;
      `REG_IAM: rd_mux = iam_q;
      `REG_IBM: rd_mux = ibm_q;
      `REG_DESIRED_VALUE_A: rd_mux = dva_q;
      `REG_DESIRED_VALUE_B: rd_mux = dvb_q;
      `REG_IAE: rd_mux = iae_q;
      `REG_IBE: rd_mux = ibe_q;
      `REG_PCR: rd_mux = pcr_q;
      `REG_ICR: rd_mux = icr_q;
      `REG_FCR: rd_mux = fcr_q;
      default: rd_mux = `RST_BYTE;
    endcase
  end

  // Configuration registers and power-up restore of the desired values
  always @(posedge clk) begin
    if (rst) begin
      tbl_q <= `RST_BYTE;
      dva_q <= `RST_BYTE;
      dvb_q <= `RST_BYTE;
      pcr_q <= `RST_BYTE;
      dda_q <= `RST_BYTE;
      ddb_q <= `RST_BYTE;
      iam_q <= `RST_BYTE;
      ibm_q <= `RST_BYTE;
      icr_q <= `RST_BYTE;
      restore_q <= 1'b1;
    end else begin
      restore_q <= 1'b0;
      if (restore_q) begin
        dva_q <= nv_restore_a;
        dvb_q <= nv_restore_b;
      end else if (wr_cmd) begin
        case (cmd_reg)
          `REG_TBL: tbl_q <= cmd_wdata;
          `REG_DESIRED_VALUE_A: dva_q <= cmd_wdata;
          `REG_DESIRED_VALUE_B: dvb_q <= cmd_wdata;
          `REG_PCR: pcr_q <= cmd_wdata;
          `REG_DIRECTION_A: dda_q <= cmd_wdata;
          `REG_DIRECTION_B: ddb_q <= cmd_wdata;
          `REG_IAM: iam_q <= cmd_wdata;
          `REG_IBM: ibm_q <= cmd_wdata;
          `REG_ICR: icr_q <= cmd_wdata & `ICR_WMASK;
          default: tbl_q <= tbl_q;
        endcase
      end
    end
  end

  // Nonvolatile write starts; the memory engine mirrors the desired values
  always @(posedge clk) begin
    if (rst) begin
      nv_write_a_q <= 1'b0;
      nv_write_b_q <= 1'b0;
      nv_write_b_mask_q <= `RST_BYTE;
    end else begin
      nv_write_a_q <= wr_dva & ~hs & ~restore_q;
      nv_write_b_q <= wr_dvb & ~restore_q;
      if (wr_dvb) begin
        nv_write_b_mask_q <= hs ? `NV_B_ALWAYS : 8'hff;
      end
    end
  end

  // Input latches, fault flags and handshake flags
  always @(posedge clk) begin
    if (rst) begin
      pal_q <= `RST_BYTE;
      pbl_q <= `RST_BYTE;
      iae_q <= `RST_BYTE;
      ibe_q <= `RST_BYTE;
      rdr_q <= 1'b0;
      xre_q <= `RST_XRE;
      bi_q <= BI_IDLE;
    end else begin
      bi_q <= bi_d;
      if (pal_on_read) begin
        pal_q <= sense_a;
      end else if (pal_on_hs) begin
        pal_q <= pa_s;
      end
      if (rd_pbl) begin
        pbl_q <= pb_s;
      end
      // Level compare every cycle; handshake pins are never monitored
      iae_q <= (sense_a ^ dva_q) & ~iam_q & {8{~hs}};
      ibe_q <= (pb_s ^ dvb_q) & ~ibm_q & ~hs_mask;
      if (rdr_set) begin
        rdr_q <= 1'b1;
      end else if (rdr_clr) begin
        rdr_q <= 1'b0;
      end
      if (xre_set) begin
        xre_q <= 1'b1;
      end else if (xre_clr) begin
        xre_q <= 1'b0;
      end
    end
  end

  // Failed command record and flag; a new failure outweighs the clearing read
  always @(posedge clk) begin
    if (rst) begin
      fcr_q <= `RST_BYTE;
      fc_q <= `RST_FC;
    end else begin
      if (bad_cmd) begin
        fcr_q <= bad_cmd_opcode_fault ? `FCR_UNKNOWN : bad_cmd_opcode;
        fc_q <= 1'b1;
      end else if (rd_fcr) begin
        fc_q <= 1'b0;
      end
    end
  end

  // Interrupt requests are held until the failed record is read
  always @(posedge clk) begin
    if (rst) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      intr_out_a <= 1'b0;
      intr_out_b <= 1'b0;
    end else begin
      if (src_a) begin
        irq_a_q <= 1'b1;
      end else if (rd_fcr) begin
        irq_a_q <= 1'b0;
      end
      if (src_b) begin
        irq_b_q <= 1'b1;
      end else if (rd_fcr) begin
        irq_b_q <= 1'b0;
      end
      intr_out_a <= req_a & icr_q[`ICR_ENA] & pce_s & ~rd_fcr;
      intr_out_b <= req_b & icr_q[`ICR_ENB] & pce_s & ~rd_fcr;
    end
  end

  // Pin outputs and read answer
  always @(posedge clk) begin
    if (rst) begin
      pa_out_q <= `RST_BYTE;
      pa_oe_q <= `RST_BYTE;
      pb_out_q <= `RST_BYTE;
      pb_oe_q <= `RST_BYTE;
      rd_data_q <= `RST_BYTE;
      rd_valid_q <= 1'b0;
    end else begin
      pa_out_q <= dva_q;
      pa_oe_q <= pa_oe_d;
      pb_out_q <= pb_out_d;
      pb_oe_q <= pb_oe_d;
      rd_valid_q <= rd_cmd;
      if (rd_cmd) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  assign desired_value_a = dva_q;
  assign desired_value_b = dvb_q;
  assign upper_threshold_code = tbl_q[`TBL_TU_HI:`TBL_TU_LO];
  assign lower_threshold_code = tbl_q[`TBL_TL_HI:`TBL_TL_LO];
  assign analog_select = tbl_q[`TBL_ADS];
  assign block_lock = tbl_q[`TBL_BL];
  assign rx_ready_flag = rdr_q;
  assign tx_empty_flag = xre_q;
  assign bad_cmd_flag = fc_q;

endmodule // port_io_fault_monitor
`default_nettype wire

// file: verif/port_io_fault_monitor_asserts.sv
// Checker for the port configuration and fault monitor block
`timescale 1ns/1ns
`default_nettype none
`include "port_io_fault_monitor_defs.vh"

module port_io_fault_monitor_asserts (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic cmd_valid, // Command strobe
  input wire logic cmd_write, // Write flag
  input wire logic [3:0] cmd_reg, // Index
  input wire logic [7:0] cmd_wdata, // Write data
  input wire logic [7:0] rd_data_q, // Read data
  input wire logic rd_valid_q, // Read valid
  input wire logic bad_cmd, // Bad command pulse
  input wire logic [7:0] nv_restore_a, // Stored A
  input wire logic [7:0] nv_restore_b, // Stored B
  input wire logic nv_write_a_q, // Store A
  input wire logic nv_write_b_q, // Store B
  input wire logic [7:0] nv_write_b_mask_q, // Stored B bits
  input wire logic [7:0] desired_value_a, // Desired A
  input wire logic [7:0] desired_value_b, // Desired B
  input wire logic [7:0] pa_oe_q, // A enables
  input wire logic [7:0] pb_out_q, // B drive
  input wire logic port_enable_in, // Port enable
  input wire logic intr_out_a, // Interrupt A
  input wire logic intr_out_b, // Interrupt B
  input wire logic rx_ready_flag, // Receive ready
  input wire logic bad_cmd_flag // Failed command
);
  logic [7:0] pcr_q;
  logic [7:0] dir_a_q;
  logic [2:0] quiet_q;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Shadow of config; quiet counter lets synced outputs catch up before checks
  always @(posedge clk) begin
    if (rst) begin
      pcr_q <= 8'h00;
      dir_a_q <= 8'h00;
      quiet_q <= 3'h0;
    end else if (cmd_valid && cmd_write && (cmd_reg == `REG_PCR || cmd_reg == `REG_DIRECTION_A)) begin
      if (cmd_reg == `REG_PCR) pcr_q <= cmd_wdata;
      else dir_a_q <= cmd_wdata;
      quiet_q <= 3'h0;
    end else if (quiet_q != 3'h7) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end

  sequence wr_cmd(logic [3:0] r);
    cmd_valid && cmd_write && cmd_reg == r;
  endsequence
  sequence rd_cmd(logic [3:0] r);
    cmd_valid && !cmd_write && cmd_reg == r;
  endsequence

  restore_load_a: assert property ($fell(rst) |=>
    desired_value_a == $past(nv_restore_a) && desired_value_b == $past(nv_restore_b))
    else $error("desired values not restored");
  des_write_a: assert property (wr_cmd(`REG_DESIRED_VALUE_A) |=> desired_value_a == $past(cmd_wdata))
    else $error("desired A not written");
  nv_mode_a: assert property (wr_cmd(`REG_DESIRED_VALUE_A) |=> nv_write_a_q == !$past(pcr_q[5]))
    else $error("store of desired A wrong for mode");
  nv_b_mask_a: assert property (wr_cmd(`REG_DESIRED_VALUE_B) |=>
    nv_write_b_q && nv_write_b_mask_q == ($past(pcr_q[5]) ? 8'h0f : 8'hff))
    else $error("store of desired B wrong");
  icr_top_a: assert property (rd_cmd(`REG_ICR) |=> rd_valid_q && !rd_data_q[7])
    else $error("interrupt config top bit not zero");
  fc_set_a: assert property (bad_cmd |=> bad_cmd_flag)
    else $error("failed command flag not set");
  fc_clear_a: assert property (rd_cmd(`REG_FCR) and !bad_cmd |=> !bad_cmd_flag)
    else $error("failed command flag not cleared");
  pe_mute_a: assert property (!port_enable_in [*5] |-> !intr_out_a && !intr_out_b)
    else $error("interrupt while port disabled");
  gen_dir_a: assert property (quiet_q == 3'h7 && !pcr_q[5] && !pcr_q[6] |-> pa_oe_q == dir_a_q)
    else $error("port A enables differ from direction");
  hs_dir_a: assert property (quiet_q == 3'h7 && pcr_q[5:4] == 2'b10 |-> pa_oe_q == 8'h00)
    else $error("input handshake drives port A");
  ready_lvl_a: assert property (quiet_q == 3'h7 && pcr_q[5:2] == 4'b1010 &&
    $stable(rx_ready_flag) |-> pb_out_q[6] == (pcr_q[0] ^ rx_ready_flag))
    else $error("ready output level wrong");
endmodule // port_io_fault_monitor_asserts

bind port_io_fault_monitor port_io_fault_monitor_asserts chk (.clk, .rst, .cmd_valid,
  .cmd_write, .cmd_reg, .cmd_wdata, .rd_data_q, .rd_valid_q, .bad_cmd, .nv_restore_a,
  .nv_restore_b, .nv_write_a_q, .nv_write_b_q, .nv_write_b_mask_q, .desired_value_a,
  .desired_value_b, .pa_oe_q, .pb_out_q, .port_enable_in, .intr_out_a, .intr_out_b,
  .rx_ready_flag, .bad_cmd_flag);
`default_nettype wire

// file: verif/port_io_peripheral.sv
// Peripheral model on the port pins
`timescale 1ns/1ns
`default_nettype none

module port_io_peripheral (
  input wire logic clk, // Clock
  input wire logic [7:0] pa_out_q, // A drive
  input wire logic [7:0] pa_oe_q, // A enables
  input wire logic [7:0] pb_out_q, // B drive
  input wire logic [7:0] pb_oe_q, // B enables
  output logic [7:0] pa_in, // A levels
  output logic [7:0] pa_analog_in, // A comparator
  output logic [7:0] pb_in // B levels
);
  logic [7:0] ext_a = 8'h00;
  logic [7:0] ext_b = 8'h80;

  // Pin level: the block wins where it drives, the peripheral elsewhere
  assign pa_in = (pa_oe_q & pa_out_q) | (~pa_oe_q & ext_a);
  assign pa_analog_in = pa_in;
  assign pb_in = (pb_oe_q & pb_out_q) | (~pb_oe_q & ext_b);

  // Falling strobe with data held across it; hold sets a prompt or slow peer
  task strobe(input logic [7:0] data, input int hold);
    @(negedge clk);
    ext_a = data;
    @(negedge clk);
    ext_b[7] = 1'b0;
    repeat (hold) @(negedge clk);
    ext_b[7] = 1'b1;
  endtask
endmodule // port_io_peripheral
`default_nettype wire

// file: verif/port_io_fault_monitor_tb_top.sv
// Testbench for the port configuration and fault monitor block
`timescale 1ns/1ns
`default_nettype none
`include "port_io_fault_monitor_defs.vh"

module port_io_fault_monitor_tb_top;
  logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0;
  logic [3:0] cmd_reg = 4'h0;
  logic [7:0] cmd_wdata = 8'h00, bad_cmd_opcode = 8'h00;
  logic bad_cmd = 1'b0, bad_cmd_opcode_fault = 1'b0, port_enable_in = 1'b1;
  logic [7:0] rd_data_q, pa_in, pa_out_q, pa_oe_q, pa_analog_in, pb_in, pb_out_q, pb_oe_q;
  logic [7:0] desired_value_a, desired_value_b, nv_write_b_mask_q;
  logic rd_valid_q, nv_write_a_q, nv_write_b_q, intr_out_a, intr_out_b;
  logic analog_select, block_lock, rx_ready_flag, tx_empty_flag, bad_cmd_flag;
  logic [2:0] upper_threshold_code, lower_threshold_code;
  int bad_count = 0, n_compared = 0, i;

  port_io_fault_monitor dut (.clk, .rst, .cmd_valid, .cmd_write, .cmd_reg, .cmd_wdata,
    .rd_data_q, .rd_valid_q, .bad_cmd, .bad_cmd_opcode_fault, .bad_cmd_opcode,
    .nv_restore_a(8'h3c), .nv_restore_b(8'ha5), .nv_write_a_q, .nv_write_b_q,
    .nv_write_b_mask_q, .desired_value_a, .desired_value_b, .pa_in, .pa_out_q, .pa_oe_q,
    .pa_analog_in, .pb_in, .pb_out_q, .pb_oe_q, .port_enable_in, .intr_out_a, .intr_out_b,
    .upper_threshold_code, .lower_threshold_code, .analog_select, .block_lock,
    .rx_ready_flag, .tx_empty_flag, .bad_cmd_flag);
  port_io_peripheral peri (.clk, .pa_out_q, .pa_oe_q, .pb_out_q, .pb_oe_q, .pa_in,
    .pa_analog_in, .pb_in);

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  task summarize;
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One command per call, with an idle cycle so strobes never change twice in a step
  task wr(input logic [3:0] r, input logic [7:0] d);
    @(negedge clk);
    {cmd_valid, cmd_write, cmd_reg, cmd_wdata} = {2'b11, r, d};
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task rd(input logic [3:0] r, input logic [7:0] exp);
    @(negedge clk);
    {cmd_valid, cmd_write, cmd_reg} = {2'b10, r};
    @(negedge clk);
    cmd_valid = 1'b0;
    check("rd_valid_q", {7'h0, rd_valid_q}, 8'h01);
    check("rd_data_q", rd_data_q, exp);
  endtask

  task fail_cmd(input logic f, input logic [7:0] op);
    @(negedge clk);
    {bad_cmd, bad_cmd_opcode_fault, bad_cmd_opcode} = {1'b1, f, op};
    @(negedge clk);
    bad_cmd = 1'b0;
  endtask

  // Synced pins, flags and interrupt outputs need up to five cycles; settle waits six
  task settle;
    repeat (6) @(negedge clk);
  endtask

  task intr(input logic [1:0] exp);
    settle();
    check("intr", {6'h0, intr_out_a, intr_out_b}, {6'h0, exp});
  endtask

  // Hang guard
  initial begin
    #400000;
    bad_count++;
    summarize();
  end

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("desired_value_a", desired_value_a, 8'h3c);
    check("desired_value_b", desired_value_b, 8'ha5);
    rd(4'hc, 8'h00);
    wr(`REG_ICR, 8'hff);
    rd(`REG_ICR, 8'h7f);
    wr(`REG_TBL, 8'h9a);
    check("thresholds", {upper_threshold_code, lower_threshold_code, analog_select, block_lock},
      8'h9a);
    for (i = 3; i < 7; i++) begin
      wr(i[3:0], 8'h30 + i[7:0]);
      rd(i[3:0], 8'h30 + i[7:0]);
    end
    wr(`REG_TBL, 8'h00);
    wr(`REG_DIRECTION_A, 8'h00);
    wr(`REG_DIRECTION_B, 8'h00);
    wr(`REG_IAM, 8'h00);
    wr(`REG_IBM, 8'hff);
    // Failed command record and its interrupt
    rd(`REG_FCR, 8'h00);
    check("bad_cmd_flag", {7'h0, bad_cmd_flag}, 8'h00);
    fail_cmd(1'b1, 8'h00);
    rd(`REG_FCR, 8'hff);
    fail_cmd(1'b0, 8'h3b);
    rd(`REG_FCR, 8'h3b);
    wr(`REG_ICR, 8'h03);
    rd(`REG_FCR, 8'h3b);
    fail_cmd(1'b1, 8'h00);
    intr(2'b00);
    rd(`REG_FCR, 8'hff);
    wr(`REG_ICR, 8'h23);
    fail_cmd(1'b0, 8'h3b);
    intr(2'b11);
    rd(`REG_FCR, 8'h3b);
    intr(2'b00);
    // Fault monitoring in general mode
    wr(`REG_ICR, 8'h00);
    wr(`REG_DESIRED_VALUE_A, 8'h5a);
    peri.ext_a = 8'h5a;
    peri.ext_b = 8'h96;
    settle();
    rd(`REG_IAE, 8'h00);
    rd(`REG_PBL, 8'h96);
    peri.ext_a = 8'h5b;
    settle();
    rd(`REG_IAE, 8'h01);
    rd(`REG_PAL, 8'h5b);
    wr(`REG_IAM, 8'h01);
    settle();
    rd(`REG_IAE, 8'h00);
    wr(`REG_IAM, 8'h00);
    wr(`REG_ICR, 8'h07);
    intr(2'b10);
    port_enable_in = 1'b0;
    intr(2'b00);
    port_enable_in = 1'b1;
    wr(`REG_ICR, 8'h47);
    intr(2'b11);
    peri.ext_a = 8'h5a;
    settle();
    rd(`REG_FCR, 8'h3b);
    intr(2'b00);
    wr(`REG_ICR, 8'h03);
    peri.ext_a = 8'h5b;
    intr(2'b00);
    // Direction, enable mode and output mode tri-state
    wr(`REG_DIRECTION_A, 8'hf0);
    settle();
    check("pa_oe_q", pa_oe_q, 8'hf0);
    wr(`REG_PCR, 8'h40);
    port_enable_in = 1'b0;
    settle();
    check("pa_oe_q", pa_oe_q, 8'h00);
    port_enable_in = 1'b1;
    wr(`REG_PCR, 8'hb0);
    settle();
    check("pa_oe_q", pa_oe_q, 8'h00);
    wr(`REG_PCR, 8'h30);
    settle();
    check("pa_oe_q", pa_oe_q, 8'hff);
    // Single read handshake, interlocked, active high ready
    wr(`REG_PCR, 8'h29);
    wr(`REG_DESIRED_VALUE_A, 8'h11);
    wr(`REG_DESIRED_VALUE_B, 8'h22);
    peri.strobe(8'hc3, 3);
    for (i = 0; i < 20 && rx_ready_flag !== 1'b1; i++) @(negedge clk);
    check("rx_ready_flag", {7'h0, rx_ready_flag}, 8'h01);
    rd(`REG_PAL, 8'hc3);
    settle();
    check("rx_ready_flag", {7'h0, rx_ready_flag}, 8'h00);
    summarize();
  end
endmodule // port_io_fault_monitor_tb_top
`default_nettype wire
